// ---- rtl/scfg_pkg.sv ----
// constants for the configuration-header register bank of the storage controller
// assumes a 32-bit AXI4-Lite register port and a 125 MHz controller clock
package scfg_pkg;
  // ==========================================================================
  // register indices (printed offsets; byte address is four times the index)
  // ==========================================================================
  localparam logic [5:0] IDX_SELF_TEST = 6'h0F; // self_test_control
  localparam logic [5:0] IDX_MEM_LO = 6'h10; // mem_window_lo
  localparam logic [5:0] IDX_MEM_HI = 6'h14; // mem_window_hi
  localparam logic [5:0] IDX_IO_PAIR = 6'h18; // io_pair_window
  localparam logic [5:0] IDX_VEND3 = 6'h1C; // first vendor window
  localparam logic [5:0] IDX_VEND4 = 6'h20; // second vendor window
  localparam logic [5:0] IDX_VEND5 = 6'h24; // third vendor window
  localparam logic [5:0] IDX_CIS = 6'h28; // cis_link_unused
  localparam logic [5:0] IDX_SUBSYS = 6'h2C; // subsystem_ident
  localparam logic [5:0] IDX_EXPANSION_ROM_WINDOW = 6'h30; // expansion_rom_window
  localparam logic [5:0] IDX_FEAT = 6'h34; // feature_list_head
  localparam logic [5:0] IDX_IRQ = 6'h3C; // interrupt_routing
  localparam logic [5:0] IDX_MIN_GNT = 6'h3E; // min_grant_unused
  // ==========================================================================
  // self-test byte fields
  // ==========================================================================
  localparam int ST_PRESENT_BIT = 7; // selftest_present
  localparam int ST_TRIGGER_BIT = 6; // selftest_trigger
  localparam int ST_RESULT_W = 4; // selftest_result width, bits 3:0
  // ==========================================================================
  // window field positions and reset values
  // ==========================================================================
  localparam int MEM_MIN_LOG2 = 14; // 16 KiB smallest memory window
  localparam int IO_BASE_LSB = 3; // 8-byte index/data pair
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000; // reset and fixed zero
  localparam logic [1:0] KIND_32BIT = 2'h0; // mapping_kind: below 4 GiB
  localparam logic [1:0] KIND_64BIT = 2'h2; // mapping_kind: anywhere in 64-bit
  localparam logic [7:0] VECTOR_RESET = 8'h00; // irq_vector_note reset
  // ==========================================================================
  // bus answers
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 8000; // 125 MHz
  localparam int SELFTEST_TIME_NS = 1000; // length of one built-in test run
  localparam int SELFTEST_CYCLES =
    (SELFTEST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STRAP_SETTLE = 3; // edges before straps are captured
endpackage : scfg_pkg

// ---- rtl/scfg_regs.sv ----
// configuration-header register bank, bytes 0Fh to 3Eh of the header
// assumes an AXI4-Lite master on sys_clk, straps on pins, and a test engine
// that presents its completion code on selftest_code in the same clock domain
`timescale 1ns/1ns
module scfg_regs #(
  parameter bit SELFTEST_IMPL = 1'b1, // self-test byte present
  parameter int SELFTEST_CYCLES = scfg_pkg::SELFTEST_CYCLES, // test run length
  parameter int MEM_WIN_LOG2 = scfg_pkg::MEM_MIN_LOG2, // window size, at least 14
  parameter bit BEHIND_BRIDGE = 1'b0, // endpoint behind a bridge
  parameter logic [1:0] MAP_KIND = scfg_pkg::KIND_64BIT, // mapping_kind value
  parameter bit IO_WINDOW = 1'b1, // third window is the io pair
  parameter bit EXPANSION_ROM_WINDOW_IMPL = 1'b0, // option ROM window present
  parameter logic [7:0] FEATURE_OFFSET = 8'h40, // first_feature_offset
  parameter logic [7:0] IRQ_PIN = 8'h01 // irq_pin_select
) (
  input wire logic sys_clk,
  input wire logic reset,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // strap pins, asynchronous to sys_clk
  input wire logic [15:0] subsystem_number,
  input wire logic [15:0] subsystem_maker_number,
  // built-in test engine
  input wire logic [3:0] selftest_code,
  output logic selftest_busy,
  // decoded placements for the address decoders
  output logic [63:0] mem_window_base,
  output logic [31:0] io_pair_base,
  output logic [31:0] option_rom_addr,
  output logic [7:0] irq_vector_note
);
  // ==========================================================================
  // helpers
  // ==========================================================================
  // byte-lane merge of a write into an old word, restricted to writable bits
  function automatic logic [31:0] merge_wr(input logic [31:0] old_v,
    input logic [31:0] wd, input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge_wr = (wd & lanes) | (old_v & ~lanes);
  endfunction : merge_wr

  // index of a register from a byte address
  function automatic logic [5:0] idx_of(input logic [7:0] addr);
    idx_of = addr[7:2];
  endfunction : idx_of

  // writable masks; fixed bits never reach storage
  localparam logic [31:0] MEM_LO_WMASK = 32'hFFFF_FFFF << MEM_WIN_LOG2;
  localparam logic [31:0] MEM_HI_WMASK = BEHIND_BRIDGE ? 32'h0 : 32'hFFFF_FFFF;
  localparam logic [31:0] IO_WMASK = IO_WINDOW ?
    (32'hFFFF_FFFF << scfg_pkg::IO_BASE_LSB) : 32'hFFFF_FFFE;
  localparam logic [31:0] EXPANSION_ROM_WINDOW_WMASK = EXPANSION_ROM_WINDOW_IMPL ? 32'hFFFF_FFFF : 32'h0;
  localparam logic [1:0] KIND_EFF = BEHIND_BRIDGE ? scfg_pkg::KIND_32BIT : MAP_KIND;
  localparam logic [15:0] ST_CNT_LAST = 16'(SELFTEST_CYCLES - 1);

  // ==========================================================================
  // bus slave state
  // ==========================================================================
  logic aw_have_r; // write address held
  logic [5:0] aw_idx_r; // held write index
  logic w_have_r; // write data held
  logic [31:0] w_data_r; // held write data
  logic [3:0] w_strb_r; // held byte strobes
  logic bvalid_r; // write answer pending
  logic [1:0] bresp_r; // write answer code
  logic rvalid_r; // read answer pending
  logic [1:0] rresp_r; // read answer code
  logic [31:0] rdata_r; // read answer data
  logic [5:0] rd_idx_r; // index of the answered read, for checks

  // one write and one read at most; new address waits for the answer to drain
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire wr_go = aw_have_r && w_have_r && !bvalid_r; // write takes effect here

  // decode of the held write index
  wire wr_st = wr_go && (aw_idx_r == scfg_pkg::IDX_SELF_TEST);
  wire wr_mlo = wr_go && (aw_idx_r == scfg_pkg::IDX_MEM_LO);
  wire wr_mhi = wr_go && (aw_idx_r == scfg_pkg::IDX_MEM_HI);
  wire wr_io = wr_go && (aw_idx_r == scfg_pkg::IDX_IO_PAIR);
  wire wr_expansion_rom_window = wr_go && (aw_idx_r == scfg_pkg::IDX_EXPANSION_ROM_WINDOW);
  wire wr_irq = wr_go && (aw_idx_r == scfg_pkg::IDX_IRQ);
  wire wr_vend = wr_go && (aw_idx_r == scfg_pkg::IDX_VEND3 ||
    aw_idx_r == scfg_pkg::IDX_VEND4 || aw_idx_r == scfg_pkg::IDX_VEND5);
  wire [1:0] vend_sel = 2'(aw_idx_r[5:2] - 4'h7); // 1Ch,20h,24h -> 0,1,2

  // ==========================================================================
  // storage
  // ==========================================================================
  logic [31:0] mem_lo_r; // only writable bits stored
  logic [31:0] mem_hi_r;
  logic [31:0] io_r;
  logic [31:0] expansion_rom_window_r;
  logic [31:0] vend_r [0:2]; // vendor windows three to five
  logic [7:0] vector_r;
  logic st_trig_r; // selftest_trigger
  logic [3:0] st_res_r; // selftest_result
  logic [15:0] st_cnt_r; // cycles into the current run
  logic [31:0] ss_r; // captured subsystem identifiers
  logic ss_loaded_r; // straps captured since reset
  logic [1:0] settle_r; // edges since reset release
  logic [31:0] strap_s1_r, strap_s2_r; // two-stage strap synchroniser

  // ==========================================================================
  // write address and data capture, either order
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
    end else begin
      // a held half is released when the response is issued
      if (aw_fire) aw_have_r <= 1'b1;
      else if (wr_go) aw_have_r <= 1'b0;
      if (w_fire) w_have_r <= 1'b1;
      else if (wr_go) w_have_r <= 1'b0;
    end
  end

  // payload registers need no reset; flags above qualify them
  always_ff @(posedge sys_clk) begin
    if (aw_fire) aw_idx_r <= idx_of(s_axi_awaddr);
    if (w_fire) begin
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
  end

  // a write to an index outside the map is answered with an error
  wire wr_mapped = (aw_idx_r == scfg_pkg::IDX_SELF_TEST) || wr_mlo || wr_mhi || wr_io ||
    wr_vend || wr_expansion_rom_window || wr_irq || (aw_idx_r == scfg_pkg::IDX_CIS) ||
    (aw_idx_r == scfg_pkg::IDX_SUBSYS) || (aw_idx_r == scfg_pkg::IDX_FEAT) ||
    (aw_idx_r == scfg_pkg::IDX_MIN_GNT);

  // write response follows both halves
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bvalid_r <= 1'b0;
      bresp_r <= scfg_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? scfg_pkg::RESP_OKAY : scfg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ==========================================================================
  // placement registers
  // ==========================================================================
  // placement bits
  always_ff @(posedge sys_clk) begin
    if (reset) mem_lo_r <= scfg_pkg::WORD_ZERO;
    else if (wr_mlo) mem_lo_r <= merge_wr(mem_lo_r, w_data_r, w_strb_r, MEM_LO_WMASK);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) mem_hi_r <= scfg_pkg::WORD_ZERO;
    else if (wr_mhi) mem_hi_r <= merge_wr(mem_hi_r, w_data_r, w_strb_r, MEM_HI_WMASK);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) io_r <= scfg_pkg::WORD_ZERO;
    else if (wr_io) io_r <= merge_wr(io_r, w_data_r, w_strb_r, IO_WMASK);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) expansion_rom_window_r <= scfg_pkg::WORD_ZERO;
    else if (wr_expansion_rom_window) expansion_rom_window_r <= merge_wr(expansion_rom_window_r, w_data_r, w_strb_r, EXPANSION_ROM_WINDOW_WMASK);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) vend_r[i] <= scfg_pkg::WORD_ZERO;
    end else if (wr_vend) begin
      vend_r[vend_sel] <= merge_wr(vend_r[vend_sel], w_data_r, w_strb_r, 32'hFFFF_FFFF);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) vector_r <= scfg_pkg::VECTOR_RESET;
    else if (wr_irq && w_strb_r[0]) vector_r <= w_data_r[7:0];
  end

  // ==========================================================================
  // self-test sequencing
  // ==========================================================================
  // a host write of one while a run is going is ignored; the run is not restarted
  wire st_start = SELFTEST_IMPL && wr_st && w_strb_r[0] &&
    w_data_r[scfg_pkg::ST_TRIGGER_BIT] && !st_trig_r;
  wire st_done = st_trig_r && (st_cnt_r == ST_CNT_LAST);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_trig_r <= 1'b0;
      st_cnt_r <= 16'h0000;
      st_res_r <= 4'h0;
    end else if (st_start) begin
      st_trig_r <= 1'b1;
      st_cnt_r <= 16'h0000;
    end else if (st_done) begin
      st_trig_r <= 1'b0;
      st_res_r <= selftest_code;
    end else if (st_trig_r) begin
      st_cnt_r <= st_cnt_r + 16'h0001;
    end
  end
  assign selftest_busy = st_trig_r;

  // ==========================================================================
  // strap capture at initialisation
  // ==========================================================================
  // straps pass two flops; capture waits until the second stage holds a sample
  always_ff @(posedge sys_clk) begin
    strap_s1_r <= {subsystem_number, subsystem_maker_number};
    strap_s2_r <= strap_s1_r;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      settle_r <= 2'h0;
      ss_loaded_r <= 1'b0;
      ss_r <= scfg_pkg::WORD_ZERO;
    end else if (!ss_loaded_r) begin
      settle_r <= settle_r + 2'h1;
      if (settle_r == 2'(scfg_pkg::STRAP_SETTLE - 1)) begin
        ss_loaded_r <= 1'b1;
        ss_r <= strap_s2_r;
      end
    end
  end

  // ==========================================================================
  // read views
  // ==========================================================================
  // absent byte zero
  wire [7:0] st_view = SELFTEST_IMPL ?
    {1'b1, st_trig_r, 2'b00, st_res_r} : 8'h00;
  wire [31:0] mem_lo_view = {mem_lo_r[31:4], 1'b0, KIND_EFF, 1'b0};
  wire [31:0] io_view = {io_r[31:1], IO_WINDOW};
  wire [31:0] irq_view = {16'h0000, IRQ_PIN, vector_r};

  assign mem_window_base = {mem_hi_r, mem_lo_view[31:4], 4'h0};
  assign io_pair_base = IO_WINDOW ? {io_r[31:3], 3'b000} : 32'h0;
  assign option_rom_addr = expansion_rom_window_r;
  assign irq_vector_note = vector_r;

  // read mux; words fall through to zero
  wire [5:0] ar_idx = idx_of(s_axi_araddr);
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_word = scfg_pkg::WORD_ZERO;
    rd_hit = 1'b1;
    unique case (ar_idx)
      scfg_pkg::IDX_SELF_TEST: rd_word = {24'h0, st_view};
      scfg_pkg::IDX_MEM_LO: rd_word = mem_lo_view;
      scfg_pkg::IDX_MEM_HI: rd_word = mem_hi_r;
      scfg_pkg::IDX_IO_PAIR: rd_word = io_view;
      scfg_pkg::IDX_VEND3: rd_word = vend_r[0];
      scfg_pkg::IDX_VEND4: rd_word = vend_r[1];
      scfg_pkg::IDX_VEND5: rd_word = vend_r[2];
      scfg_pkg::IDX_CIS: rd_word = scfg_pkg::WORD_ZERO;
      scfg_pkg::IDX_SUBSYS: rd_word = ss_r;
      scfg_pkg::IDX_EXPANSION_ROM_WINDOW: rd_word = expansion_rom_window_r;
      scfg_pkg::IDX_FEAT: rd_word = {24'h0, FEATURE_OFFSET};
      scfg_pkg::IDX_IRQ: rd_word = irq_view;
      scfg_pkg::IDX_MIN_GNT: rd_word = scfg_pkg::WORD_ZERO;
      default: rd_hit = 1'b0;
    endcase
  end

  // read answer registered on the same edge that takes the address
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rresp_r <= scfg_pkg::RESP_OKAY;
      rdata_r <= scfg_pkg::WORD_ZERO;
      rd_idx_r <= 6'h00;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? scfg_pkg::RESP_OKAY : scfg_pkg::RESP_SLVERR;
      rdata_r <= rd_word;
      rd_idx_r <= ar_idx;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  AST_SELFTEST_ABSENT: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!SELFTEST_IMPL && rvalid_r && rd_idx_r == scfg_pkg::IDX_SELF_TEST) |-> rdata_r == 32'h0)
    else $error("absent self-test byte read nonzero");

  AST_SELFTEST_FLAG: assert property (
    @(posedge sys_clk) disable iff (reset)
    (SELFTEST_IMPL && rvalid_r && rd_idx_r == scfg_pkg::IDX_SELF_TEST) |->
      rdata_r[scfg_pkg::ST_PRESENT_BIT])
    else $error("self-test present flag not set");

  AST_SELFTEST_ENDS: assert property (
    @(posedge sys_clk) disable iff (reset)
    (st_trig_r && st_cnt_r == ST_CNT_LAST) |=> !st_trig_r && st_res_r == $past(selftest_code))
    else $error("self-test trigger not cleared at end of run");

  AST_RESULT_ONLY_AT_END: assert property (
    @(posedge sys_clk) disable iff (reset)
    (!$stable(st_res_r) && !$past(reset)) |-> $past(st_done))
    else $error("self-test result changed outside completion");

  AST_MEM_LO_FIXED: assert property (
    @(posedge sys_clk) disable iff (reset)
    mem_lo_view[13:0] == {11'h000, KIND_EFF, 1'b0} &&
      mem_lo_view[MEM_WIN_LOG2 - 1:0] == 14'({KIND_EFF, 1'b0}))
    else $error("memory window low bits not fixed");

  AST_MEM_HI_WRITE: assert property (
    @(posedge sys_clk) disable iff (reset)
    (wr_mhi && w_strb_r == 4'hF && !BEHIND_BRIDGE) |=>
      mem_window_base[63:32] == $past(w_data_r) && s_axi_bvalid)
    else $error("upper window write not stored");

  AST_IO_FLAG: assert property (
    @(posedge sys_clk) disable iff (reset)
    IO_WINDOW |-> io_view[2:0] == 3'b001)
    else $error("io window low bits wrong");

  AST_SUBSYS_HOLD: assert property (
    @(posedge sys_clk) disable iff (reset)
    ($past(ss_loaded_r) && ss_loaded_r) |-> $stable(ss_r))
    else $error("subsystem identifiers changed after capture");

  AST_VECTOR_KEEP: assert property (
    @(posedge sys_clk) disable iff (reset)
    !(wr_irq && w_strb_r[0]) |=> $stable(vector_r))
    else $error("vector note changed without a write");

  AST_FIXED_READS_ZERO: assert property (
    @(posedge sys_clk) disable iff (reset)
    (rvalid_r && (rd_idx_r == scfg_pkg::IDX_MIN_GNT || rd_idx_r == scfg_pkg::IDX_CIS)) |->
      rdata_r == 32'h0 && rresp_r == scfg_pkg::RESP_OKAY)
    else $error("unsupported word read nonzero");

  AST_BVALID_HOLDS: assert property (
    @(posedge sys_clk) disable iff (reset)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped before taken");
endmodule : scfg_regs

// ---- testbench/scfg_engine_model.sv ----
// stand-in for the built-in test engine beside the register bank
// assumes busy is high for the whole of a run, same clock as the bank
`timescale 1ns/1ns
// ==========================================================================
// test engine model
// ==========================================================================
module scfg_engine_model (
  input wire logic sys_clk,
  input wire logic busy,
  input wire logic [3:0] want_code,
  output logic [3:0] selftest_code
);
  // idle code keeps flipping so a sample taken outside a run is caught
  initial selftest_code = 4'h5;
  // hold the chosen completion code while a run is in progress
  always @(posedge sys_clk) begin
    selftest_code <= busy ? want_code : ~selftest_code;
  end
endmodule : scfg_engine_model

// ---- testbench/tb_top.sv ----
// self-checking bench for the configuration-header register bank
// assumes the bank answers AXI4-Lite and runs a short self-test of 4 cycles
`timescale 1ns/1ns
// ==========================================================================
// bench top
// ==========================================================================
module tb_top;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF; // byte lanes, all on unless a scenario says otherwise
  localparam int ST_RUN = 4; // short self-test run keeps the bench fast
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, io_pair_base, option_rom_addr;
  logic [15:0] subsystem_number = 16'h0000, subsystem_maker_number = 16'h0000;
  logic [3:0] want_code = 4'h0, selftest_code;
  logic selftest_busy;
  logic [63:0] mem_window_base;
  logic [7:0] irq_vector_note;
  // expected answers, oldest first
  logic [31:0] exp_d[$];
  logic [1:0] exp_r[$], exp_b[$];
  int n_errors = 0, compares = 0;
  // register table: index, writable mask, fixed bits
  logic [5:0] t_idx [12] = '{scfg_pkg::IDX_MEM_LO, scfg_pkg::IDX_MEM_HI,
    scfg_pkg::IDX_IO_PAIR, scfg_pkg::IDX_CIS, scfg_pkg::IDX_SUBSYS, scfg_pkg::IDX_EXPANSION_ROM_WINDOW,
    scfg_pkg::IDX_FEAT, scfg_pkg::IDX_IRQ, scfg_pkg::IDX_MIN_GNT, scfg_pkg::IDX_VEND3,
    scfg_pkg::IDX_VEND4, scfg_pkg::IDX_VEND5};
  logic [31:0] t_msk [12] = '{32'hFFFF_C000, 32'hFFFF_FFFF, 32'hFFFF_FFF8, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0000_00FF, 32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
  logic [31:0] t_fix [12] = '{32'h4, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h40,
    32'h100, 32'h0, 32'h0, 32'h0, 32'h0};

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  scfg_regs #(.SELFTEST_CYCLES(ST_RUN)) uut (.sys_clk(sys_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .subsystem_number(subsystem_number), .subsystem_maker_number(subsystem_maker_number),
    .selftest_code(selftest_code), .selftest_busy(selftest_busy),
    .mem_window_base(mem_window_base), .io_pair_base(io_pair_base),
    .option_rom_addr(option_rom_addr), .irq_vector_note(irq_vector_note));

  scfg_engine_model eng (.sys_clk(sys_clk), .busy(selftest_busy), .want_code(want_code),
    .selftest_code(selftest_code));

  // ========================================================================
  // compare and closing tasks
  // ========================================================================
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask : chk_word

  task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] s);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask : chk_resp

  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  // ========================================================================
  // bus master: holds each half until taken, waits for the answer
  // ========================================================================
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    exp_b.push_back(er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'h0;
    if (n >= 50) n_errors++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    exp_d.push_back(e);
    exp_r.push_back(er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'h0;
    if (n >= 50) n_errors++;
  endtask : axi_rd

  // answer watcher: each completed beat takes the oldest note
  always @(posedge sys_clk) begin
    if (s_axi_bvalid && s_axi_bready) chk_resp("bresp", exp_b.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) begin
      chk_resp("rresp", exp_r.pop_front(), s_axi_rresp);
      chk_word("rdata", exp_d.pop_front(), s_axi_rdata);
    end
  end

  // hang guard, far beyond the 167 cycles the run needs
  initial begin
    #200000;
    n_errors++;
    test_done();
  end

  // ========================================================================
  // main sequence
  // ========================================================================
  initial begin : main
    logic [31:0] w [12];
    logic [3:0] code;
    int n;
    void'($urandom(53));
    w[0] = $urandom;
    subsystem_number <= w[0][31:16];
    subsystem_maker_number <= w[0][15:0];
    t_fix[4] = w[0];
    repeat (16) @(posedge sys_clk);
    reset <= 1'h0;
    // straps are captured a few edges after release
    repeat (4) @(posedge sys_clk);
    axi_rd({scfg_pkg::IDX_SELF_TEST, 2'h0}, 32'h80, scfg_pkg::RESP_OKAY);
    for (int i = 0; i < 9; i++) begin
      axi_rd({t_idx[i], 2'h0}, t_fix[i], scfg_pkg::RESP_OKAY);
    end
    // random words into every table entry: only writable bits may follow
    for (int i = 0; i < 12; i++) begin
      w[i] = $urandom;
      axi_wr({t_idx[i], 2'h0}, w[i], scfg_pkg::RESP_OKAY);
      axi_rd({t_idx[i], 2'h0}, (w[i] & t_msk[i]) | t_fix[i], scfg_pkg::RESP_OKAY);
    end
    chk_word("base_lo", w[0] & 32'hFFFF_C000, mem_window_base[31:0]);
    chk_word("base_hi", w[1], mem_window_base[63:32]);
    chk_word("io_base", w[2] & 32'hFFFF_FFF8, io_pair_base);
    chk_word("rom", 32'h0, option_rom_addr);
    chk_word("vector", {24'h0, w[7][7:0]}, {24'h0, irq_vector_note});
    // lane 0 held back: the vector byte must keep its value
    s_axi_wstrb <= 4'hE;
    axi_wr({scfg_pkg::IDX_IRQ, 2'h0}, ~w[7], scfg_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    chk_word("vector_kept", {24'h0, w[7][7:0]}, {24'h0, irq_vector_note});
    // unmapped place is refused both ways
    axi_wr(8'h04, $urandom, scfg_pkg::RESP_SLVERR);
    axi_rd(8'h04, 32'h0, scfg_pkg::RESP_SLVERR);
    // two self-test runs: passing code, then a failing one
    for (int k = 0; k < 2; k++) begin
      code = (k == 0) ? 4'h0 : 4'(($urandom % 15) + 1);
      want_code <= code;
      axi_wr({scfg_pkg::IDX_SELF_TEST, 2'h0}, 32'hFFFF_FFFF, scfg_pkg::RESP_OKAY);
      chk_word("busy", 32'h1, {31'h0, selftest_busy});
      n = 0;
      while (selftest_busy !== 1'h0 && n < 50) begin
        @(posedge sys_clk);
        n++;
      end
      // busy must stand for exactly one run length
      chk_word("run", ST_RUN, n);
      axi_rd({scfg_pkg::IDX_SELF_TEST, 2'h0}, {28'h8, code}, scfg_pkg::RESP_OKAY);
    end
    test_done();
  end
endmodule : tb_top
